// *** i2ca_cfg_target.sv ***
// Serial-bus target giving a bus master access to the port configuration registers
`timescale 1ns/100ps

// Behaviour
// - Write is address byte with write bit, four command bytes, four data bytes, stop.
// - First write data byte goes to bits 31:24, last to bits 7:0.
// - Command byte 0 bits 2:0 hold the operation; 011 means register write.
// - Operation 100 in command byte 0 means register read.
// - Command byte 1 bit 0 and byte 2 bit 7 form the port number.
// - Command byte 2 bits 5:2 enable register bytes 31:24 down to 7:0.
// - Address is byte 2 bits 1:0, byte 3, then two zero bits.
// - Read is a command transfer followed by a transfer returning data.
// - An address byte with bit 0 set makes the device send data.
// - Read command bytes copy the selected register into a holding buffer.
// - Read data goes out top byte first, bits 7:0 last.
// - Reading past four bytes starts over from the top buffer byte.
// - Command and data transfers may be joined by a repeated start.
// - Target address is 38h, so a write opens with 70h.
// - An invalid command leaves every register untouched.
// - Every write data byte after the fourth is not acknowledged.
module i2ca_cfg_target (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic regReq,
  output logic regWrite,
  output logic [1:0] regPort,
  output logic [3:0] regBe,
  output logic [11:0] regAddr,
  output logic [31:0] regWdata,
  input wire logic regAck,
  input wire logic [31:0] regRdata
);

  i2ca_pkg::i2ca_link_t lnk_q;
  i2ca_pkg::i2ca_link_t lnk_d;
  i2ca_pkg::i2ca_core_t core_q;
  i2ca_pkg::i2ca_core_t core_d;

  logic linkRst;
  logic [1:0] pinSync;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic reqPulse;
  logic ackPulse;
  logic addrMatch;
  logic inCmd;
  logic inData;
  logic lastCmd;
  logic lastData;
  logic opRead;
  logic opWrite;
  logic [7:0] rxNow;
  logic [7:0] txNow;
  logic [31:0] wdNow;

  function automatic logic [2:0] opOf(
    input logic [7:0] c0
  );
    opOf = c0[i2ca_pkg::OP_MSB:i2ca_pkg::OP_LSB];
  endfunction

  // Only the documented fields are picked; reserved bits fall away here
  function automatic i2ca_pkg::i2ca_req_t mkReq(
    input logic wr,
    input logic [7:0] c1,
    input logic [7:0] c2,
    input logic [7:0] c3,
    input logic [31:0] wd
  );
    i2ca_pkg::i2ca_req_t r;
    r.write = wr;
    r.port = {c1[i2ca_pkg::PSEL_HI_POS], c2[i2ca_pkg::PSEL_LO_POS]};
    r.be = c2[i2ca_pkg::BE_MSB:i2ca_pkg::BE_LSB];
    r.addr = {c2[i2ca_pkg::AHI_MSB:i2ca_pkg::AHI_LSB], c3, i2ca_pkg::ADDR_LOW};
    r.wdata = wd;
    mkReq = r;
  endfunction

  function automatic logic [7:0] byteOf(
    input logic [31:0] buf_,
    input logic [1:0] idx
  );
    logic [7:0] b;
    unique case (idx)
      2'h0: b = buf_[31:24];
      2'h1: b = buf_[23:16];
      2'h2: b = buf_[15:8];
      2'h3: b = buf_[7:0];
    endcase
    byteOf = b;
  endfunction

  // Pins and reset enter the link domain through two flops
  i2ca_sync #(.WIDTH(1)) uRstSync (
    .clk(linkClk),
    .din(rst),
    .dout(linkRst)
  );

  i2ca_sync #(.WIDTH(2)) uPinSync (
    .clk(linkClk),
    .din({scl, sdaIn}),
    .dout(pinSync)
  );

  i2ca_evt_rx uReqRx (
    .clk(clk),
    .rst(rst),
    .tgl(lnk_q.reqTgl),
    .pulse(reqPulse)
  );

  i2ca_evt_rx uAckRx (
    .clk(linkClk),
    .rst(linkRst),
    .tgl(core_q.ackTgl),
    .pulse(ackPulse)
  );

  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];
  assign sclRise = sclS & ~lnk_q.sclPrev;
  assign sclFall = ~sclS & lnk_q.sclPrev;
  assign startCond = sclS & lnk_q.sclPrev & lnk_q.sdaPrev & ~sdaS;
  assign stopCond = sclS & lnk_q.sclPrev & ~lnk_q.sdaPrev & sdaS;

  // Byte decode shared by the receive and transmit branches
  assign rxNow = {lnk_q.shift[6:0], sdaS};
  assign txNow = byteOf(lnk_q.rdBuf, lnk_q.rdIdx);
  assign wdNow = {lnk_q.wdata[23:0], rxNow};
  assign addrMatch = rxNow[i2ca_pkg::ADDR_MSB:i2ca_pkg::ADDR_LSB] == i2ca_pkg::TGT_ADDR;
  assign inCmd = lnk_q.byteIdx <= i2ca_pkg::IDX_CMD_LAST;
  assign inData = lnk_q.byteIdx <= i2ca_pkg::IDX_DATA_LAST;
  assign lastCmd = lnk_q.byteIdx == i2ca_pkg::IDX_CMD_LAST;
  assign lastData = lnk_q.byteIdx == i2ca_pkg::IDX_DATA_LAST;
  assign opRead = opOf(lnk_q.cmd[0]) == i2ca_pkg::OP_READ;
  assign opWrite = opOf(lnk_q.cmd[0]) == i2ca_pkg::OP_WRITE;

  // Link side, on the link clock
  always_comb begin
    logic [7:0] rxByte;
    logic [7:0] txByte;
    logic [31:0] wdNext;
    rxByte = rxNow;
    txByte = txNow;
    wdNext = wdNow;
    lnk_d = lnk_q;
    lnk_d.sclPrev = sclS;
    lnk_d.sdaPrev = sdaS;

    if (ackPulse) begin
      lnk_d.pending = 1'h0;
      if (!lnk_q.req.write) begin
        lnk_d.rdBuf = core_q.rdHold;
      end
    end

    if (startCond) begin
      // Also a repeated start, which joins command and data transfers
      lnk_d.state = i2ca_pkg::LS_RX;
      lnk_d.isAddr = 1'h1;
      lnk_d.bitCnt = '0;
      lnk_d.byteIdx = '0;
      lnk_d.sdaOe = 1'h0;
    end else if (stopCond) begin
      lnk_d.state = i2ca_pkg::LS_IDLE;
      lnk_d.sdaOe = 1'h0;
    end else begin
      unique case (lnk_q.state)
        i2ca_pkg::LS_IDLE: begin
          // Never hold the line low between frames
          lnk_d.sdaOe = 1'h0;
        end
        i2ca_pkg::LS_RX: begin
          if (sclRise) begin
            lnk_d.shift = rxByte;
            lnk_d.bitCnt = lnk_q.bitCnt + 3'h1;
            if (lnk_q.bitCnt == i2ca_pkg::BIT_LAST) begin
              lnk_d.state = i2ca_pkg::LS_RXACK;
              lnk_d.ackDriven = 1'h0;
              lnk_d.ackBit = 1'h0;
              if (lnk_q.isAddr) begin
                if (addrMatch) begin
                  lnk_d.isAddr = 1'h0;
                  lnk_d.isRead = rxByte[i2ca_pkg::RW_POS];
                  lnk_d.rdIdx = '0;
                  // Busy with an earlier access: refuse the transfer
                  lnk_d.ackBit = ~lnk_q.pending;
                end else begin
                  lnk_d.state = i2ca_pkg::LS_IDLE;
                end
              end else if (inCmd) begin
                lnk_d.cmd[lnk_q.byteIdx[1:0]] = rxByte;
                lnk_d.ackBit = 1'h1;
                lnk_d.byteIdx = lnk_q.byteIdx + 4'h1;
                if (lastCmd && opRead) begin
                  lnk_d.req = mkReq(
                    1'h0,
                    lnk_q.cmd[1],
                    lnk_q.cmd[2],
                    rxByte,
                    lnk_q.wdata
                  );
                  lnk_d.reqTgl = ~lnk_q.reqTgl;
                  lnk_d.pending = 1'h1;
                end
              end else if (inData) begin
                lnk_d.wdata = wdNext;
                lnk_d.ackBit = 1'h1;
                lnk_d.byteIdx = lnk_q.byteIdx + 4'h1;
                // Other operation codes are dropped without any access
                if (lastData && opWrite) begin
                  lnk_d.req = mkReq(
                    1'h1,
                    lnk_q.cmd[1],
                    lnk_q.cmd[2],
                    lnk_q.cmd[3],
                    wdNext
                  );
                  lnk_d.reqTgl = ~lnk_q.reqTgl;
                  lnk_d.pending = 1'h1;
                end
              end else begin
                lnk_d.ackBit = 1'h0;
              end
            end
          end
        end
        i2ca_pkg::LS_RXACK: begin
          if (sclFall) begin
            if (!lnk_q.ackDriven) begin
              lnk_d.ackDriven = 1'h1;
              lnk_d.sdaOe = lnk_q.ackBit;
            end else begin
              lnk_d.sdaOe = 1'h0;
              lnk_d.bitCnt = '0;
              if (!lnk_q.ackBit) begin
                lnk_d.state = i2ca_pkg::LS_IDLE;
              end else if (lnk_q.isRead) begin
                lnk_d.state = i2ca_pkg::LS_TX;
                lnk_d.shift = txByte;
                lnk_d.sdaOe = ~txByte[7];
              end else begin
                lnk_d.state = i2ca_pkg::LS_RX;
              end
            end
          end
        end
        i2ca_pkg::LS_TX: begin
          if (sclFall) begin
            if (lnk_q.bitCnt == i2ca_pkg::BIT_LAST) begin
              lnk_d.sdaOe = 1'h0;
              lnk_d.state = i2ca_pkg::LS_TXACK;
              lnk_d.mAck = 1'h0;
              // Two-bit index wraps to the top byte after the fourth
              lnk_d.rdIdx = lnk_q.rdIdx + 2'h1;
            end else begin
              lnk_d.bitCnt = lnk_q.bitCnt + 3'h1;
              lnk_d.shift = {lnk_q.shift[6:0], 1'h0};
              lnk_d.sdaOe = ~lnk_q.shift[6];
            end
          end
        end
        i2ca_pkg::LS_TXACK: begin
          if (sclRise) begin
            lnk_d.mAck = ~sdaS;
          end
          if (sclFall) begin
            if (lnk_q.mAck) begin
              lnk_d.state = i2ca_pkg::LS_TX;
              lnk_d.bitCnt = '0;
              lnk_d.shift = txByte;
              lnk_d.sdaOe = ~txByte[7];
            end else begin
              lnk_d.state = i2ca_pkg::LS_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      lnk_q <= '0;
      lnk_q.state <= i2ca_pkg::LS_IDLE;
      lnk_q.sclPrev <= i2ca_pkg::IDLE_LEVEL;
      lnk_q.sdaPrev <= i2ca_pkg::IDLE_LEVEL;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // Core side; the request word is held still by the link until the answer toggles back
  always_comb begin
    core_d = core_q;
    if (core_q.reqValid) begin
      if (regAck) begin
        core_d.reqValid = 1'h0;
        if (!core_q.req.write) begin
          core_d.rdHold = regRdata;
        end
        core_d.ackTgl = ~core_q.ackTgl;
      end
    end else if (reqPulse) begin
      core_d.req = lnk_q.req;
      core_d.reqValid = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_q <= '0;
    end else begin
      core_q <= core_d;
    end
  end

  // Open drain: the line is only ever pulled low
  assign sdaOut = lnk_q.sdaOut;
  assign sdaOe = lnk_q.sdaOe;
  assign regReq = core_q.reqValid;
  assign regWrite = core_q.req.write;
  assign regPort = core_q.req.port;
  assign regBe = core_q.req.be;
  assign regAddr = core_q.req.addr;
  assign regWdata = core_q.req.wdata;

endmodule // i2ca_cfg_target

// *** i2ca_pkg.sv ***
// Constants and types for the configuration register target port
package i2ca_pkg;

  // Target address with all address straps at zero
  localparam logic [6:0] TGT_ADDR = 7'h38;
  localparam int RW_POS = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;

  // Operation codes in the first command byte
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam int OP_MSB = 2;
  localparam int OP_LSB = 0;

  // Field positions in command bytes 1 and 2
  localparam int PSEL_HI_POS = 0;
  localparam int PSEL_LO_POS = 7;
  localparam int BE_MSB = 5;
  localparam int BE_LSB = 2;
  localparam int AHI_MSB = 1;
  localparam int AHI_LSB = 0;
  localparam logic [1:0] ADDR_LOW = 2'h0;

  // Byte positions counted from the first command byte
  localparam logic [3:0] IDX_CMD_LAST = 4'h3;
  localparam logic [3:0] IDX_DATA_LAST = 4'h7;
  localparam logic [3:0] IDX_EXTRA = 4'h8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Bus lines idle high
  localparam logic IDLE_LEVEL = 1'h1;

  typedef enum logic [4:0] {
    LS_IDLE = 5'h01,
    LS_RX = 5'h02,
    LS_RXACK = 5'h04,
    LS_TX = 5'h08,
    LS_TXACK = 5'h10
  } i2ca_lstate_t;

  typedef struct packed {
    logic write;
    logic [1:0] port;
    logic [3:0] be;
    logic [11:0] addr;
    logic [31:0] wdata;
  } i2ca_req_t;

  typedef struct packed {
    i2ca_lstate_t state;
    logic sclPrev;
    logic sdaPrev;
    logic [7:0] shift;
    logic [2:0] bitCnt;
    logic isAddr;
    logic isRead;
    logic [3:0] byteIdx;
    logic [3:0][7:0] cmd;
    logic [31:0] wdata;
    logic ackBit;
    logic ackDriven;
    logic mAck;
    logic sdaOut;
    logic sdaOe;
    logic reqTgl;
    logic pending;
    i2ca_req_t req;
    logic [31:0] rdBuf;
    logic [1:0] rdIdx;
  } i2ca_link_t;

  typedef struct packed {
    i2ca_req_t req;
    logic reqValid;
    logic [31:0] rdHold;
    logic ackTgl;
  } i2ca_core_t;

  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
  } i2ca_evt_t;

endpackage

// *** i2ca_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/100ps
module i2ca_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // No reset here: it also carries the reset itself into the far domain
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  always_ff @(posedge clk) begin
    meta_q <= din;
    stable_q <= meta_q;
  end

  assign dout = stable_q;

endmodule // i2ca_sync

// *** i2ca_evt_rx.sv ***
// Receiver of a toggle event crossing into this clock domain
`timescale 1ns/100ps
module i2ca_evt_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic tgl,
  output logic pulse
);

  i2ca_pkg::i2ca_evt_t st_q;
  i2ca_pkg::i2ca_evt_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.meta = tgl;
    st_d.stable = st_q.meta;
    st_d.last = st_q.stable;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // One cycle per toggle of the source
  assign pulse = st_q.stable ^ st_q.last;

endmodule // i2ca_evt_rx

// *** i2ca_cfg_target_properties.sv ***
// Port-level assertions for the configuration register target
`timescale 1ns/100ps
module i2ca_cfg_target_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic regReq,
  input wire logic regWrite,
  input wire logic [1:0] regPort,
  input wire logic [3:0] regBe,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regAck,
  input wire logic [31:0] regRdata
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  a_req_holds: assert property (regReq && !regAck |=> regReq)
    else $error("request dropped before acknowledge");
  a_req_ends: assert property (regReq && regAck |=> !regReq)
    else $error("request stayed after acknowledge");
  a_fields_steady: assert property (regReq && !regAck |=>
    $stable({regWrite, regPort, regBe, regAddr, regWdata}))
    else $error("request fields moved while pending");
  a_addr_low_zero: assert property (regReq |-> regAddr[1:0] == i2ca_pkg::ADDR_LOW)
    else $error("address low bits not zero");
  a_req_spacing: assert property ($fell(regReq) |=> (!regReq) [*8])
    else $error("new request too soon after previous");
  a_reset_clear: assert property (disable iff (1'b0) rst |=>
    !regReq && regAddr == 12'h000 && regWdata == 32'h00000000)
    else $error("request outputs not cleared in reset");
  a_drive_low_only: assert property (@(posedge linkClk) disable iff (rst)
    sdaOut == 1'b0)
    else $error("data line driven high");
  a_oe_scl_low: assert property (@(posedge linkClk) disable iff (rst)
    $changed(sdaOe) |-> !scl)
    else $error("data line changed while bus clock high");
  a_oe_released: assert property (@(posedge linkClk) disable iff (rst)
    $rose(sdaOe) |-> ##[1:1000] !sdaOe)
    else $error("data line held low too long");
  c_write_done: cover property (regReq && regAck && regWrite);
  c_read_done: cover property (regReq && regAck && !regWrite);
  c_device_drives: cover property (@(posedge linkClk) $rose(sdaOe));
endmodule // i2ca_cfg_target_properties

bind i2ca_cfg_target i2ca_cfg_target_properties props (.clk(clk), .rst(rst),
  .linkClk(linkClk), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .regReq(regReq), .regWrite(regWrite), .regPort(regPort), .regBe(regBe),
  .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck), .regRdata(regRdata));

// *** i2ca_master_model.sv ***
// Behavioural bus master driving the target's serial pins
`timescale 1ns/100ps
module i2ca_master_model (
  input wire logic sda,
  output logic scl,
  output logic pullLow
);
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end
  // Data moves only while the clock is low, so no false start or stop
  task automatic bitOut(input logic b);
    #100 pullLow = !b;
    #150 scl = 1'b1;
    #250 scl = 1'b0;
  endtask
  task automatic bitIn(output logic b);
    #100 pullLow = 1'b0;
    #150 scl = 1'b1;
    #125 b = sda;
    #125 scl = 1'b0;
  endtask
  // Also serves as repeated start from a low clock
  task automatic start();
    #100 pullLow = 1'b0;
    #150 scl = 1'b1;
    #250 pullLow = 1'b1;
    #250 scl = 1'b0;
  endtask
  task automatic stop();
    #100 pullLow = 1'b1;
    #150 scl = 1'b1;
    #250 pullLow = 1'b0;
    #250;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i]);
    end
    bitIn(b);
    ack = !b;
  endtask
  task automatic getByte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitIn(d[i]);
    end
    bitOut(!ack);
  endtask
endmodule // i2ca_master_model

// *** testbench.sv ***
// Self-checking bench for the configuration register target port
`timescale 1ns/100ps
module testbench;
  logic clk, linkClk, rst, scl, sda, pullLow, sdaOut, sdaOe, regReq, regWrite, regAck, ack;
  logic [1:0] regPort;
  logic [3:0] regBe;
  logic [11:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [31:0] mem [0:3][0:1023];
  logic [7:0] d;
  i2ca_pkg::i2ca_req_t lastReq;
  int miscompares = 0, checked = 0, reqCnt = 0, ackDly = 3, waitN = 0;

  // Open-drain wire with pull-up
  assign sda = (sdaOe ? sdaOut : 1'b1) & !pullLow;

  i2ca_cfg_target DUT (.clk(clk), .rst(rst), .linkClk(linkClk), .scl(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .regReq(regReq), .regWrite(regWrite), .regPort(regPort),
    .regBe(regBe), .regAddr(regAddr), .regWdata(regWdata), .regAck(regAck),
    .regRdata(regRdata));
  i2ca_master_model bm (.sda(sda), .scl(scl), .pullLow(pullLow));

  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.3;
    forever #3 linkClk = !linkClk;
  end

  // Register file stand-in; data bus scrambles when not answering
  always @(posedge clk) begin
    regAck <= 1'b0;
    regRdata <= ~regRdata;
    if (regReq && !regAck) begin
      waitN <= waitN + 1;
      if (waitN >= ackDly) begin
        regAck <= 1'b1;
        regRdata <= mem[regPort][regAddr[11:2]];
        lastReq <= {regWrite, regPort, regBe, regAddr, regWdata};
        reqCnt <= reqCnt + 1;
        waitN <= 0;
        for (int i = 0; i < 4; i++) begin
          if (regWrite && regBe[i]) begin
            mem[regPort][regAddr[11:2]][8*i +: 8] <= regWdata[8*i +: 8];
          end
        end
      end
    end
  end

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] b [$], input int nakFrom);
    bm.start();
    foreach (b[i]) begin
      bm.sendByte(b[i], ack);
      check("ack", ack, i < nakFrom);
    end
  endtask
  task automatic readBytes(input logic [31:0] w, input int n);
    bm.start();
    bm.sendByte(8'h71, ack);
    check("rdack", ack, 1);
    for (int k = 0; k < n; k++) begin
      bm.getByte(d, k < n - 1);
      check("rd", d, w[31 - 8 * (k % 4) -: 8]);
    end
    bm.stop();
  endtask
  task automatic waitReq(input int n);
    for (int i = 0; i < 2000 && reqCnt != n; i++) begin
      @(posedge clk);
    end
    check("reqs", reqCnt, n);
    if (reqCnt != n) print_verdict();
  endtask

  initial begin
    rst = 1'b1;
    regAck = 1'b0;
    regRdata = 32'h00000000;
    mem[3][10'h2ff] = 32'haabbccdd;
    mem[1][10'h00b] = 32'h89abcdef;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    xfer('{8'h70, 8'h03, 8'h00, 8'h3c, 8'h2d, 8'h12, 8'h34, 8'h56, 8'h78}, 9);
    bm.stop();
    waitReq(1);
    check("wreq", lastReq, {1'b1, 2'h0, 4'hf, 12'h0b4, 32'h12345678});
    // Slow answer, reserved bits set, two lanes, one extra byte
    ackDly = 40;
    xfer('{8'h70, 8'hfb, 8'hc1, 8'hd6, 8'hff, 8'h11, 8'h22, 8'h33, 8'h44, 8'h99}, 9);
    bm.stop();
    waitReq(2);
    check("wreq2", lastReq, {1'b1, 2'h3, 4'h5, 12'hbfc, 32'h11223344});
    xfer('{8'h70, 8'h04, 8'h01, 8'h82, 8'hff}, 5);
    bm.stop();
    waitReq(3);
    readBytes(32'haa22cc44, 4);
    ackDly = 3;
    xfer('{8'h70, 8'h04, 8'h00, 8'h80, 8'h0b}, 5);
    waitReq(4);
    check("rreq", {lastReq.write, lastReq.port, lastReq.addr}, {1'b0, 2'h1, 12'h02c});
    readBytes(32'h89abcdef, 6);
    xfer('{8'h70, 8'h05, 8'h00, 8'h3c, 8'h2d, 8'hde, 8'had, 8'hbe, 8'hef}, 9);
    bm.stop();
    repeat (300) @(posedge clk);
    check("noreq", reqCnt, 4);
    xfer('{8'h72}, 0);
    bm.stop();
    print_verdict();
  end
endmodule // testbench
